// [rtl/ddes_top.sv]
// Cipher data path: queues, sequencing, register file and interrupt
//
// Notes on behaviour
// - Eight-word input queue, filled by CPU or DMA
// - Eight-word output queue, drained by CPU or DMA
// - Swap bit picks which written word is left
// - Swap bit picks which read word is left
// - Input space flag at 4 or 2 free
// - Output valid flag at 4 or 2 words
// - Finished blocks set output valid status once the output count reaches the threshold
// - Conditions drive interrupt or DMA request lines
// - Single DES uses key1; triple uses all
// - Queue to buffer, buffer to core timing
// - Core 20 or 60 cycles, 25/65 total
// - Core to buffer, buffer to queue timing
// - Key byte parity bits are ignored
// - Enabled status rise raises the interrupt
// - Chaining mode updates IV after each block
// - Run bit starts engine, readable in control
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module ddes_top #(
  parameter int DEPTH = ddes_pkg::QUEUE_DEPTH,
  parameter int DW    = 32
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  // Wishbone slave
  input  wire logic          wb_cyc_in,
  input  wire logic          wb_stb_in,
  input  wire logic          wb_we_in,
  input  wire logic [7:0]    wb_adr_in,
  input  wire logic [3:0]    wb_sel_in,
  input  wire logic [DW-1:0] wb_dat_in,
  output logic      [DW-1:0] wb_dat_out,
  output logic               wb_ack_out,
  // Requests
  output logic               irq_out,
  output logic               in_dma_req_out,
  output logic               out_dma_req_out
);

  localparam int CW = $clog2(DEPTH) + 1;
  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [DW-1:0]           in_mem [DEPTH];
  logic [DW-1:0]           out_mem [DEPTH];
  logic [PW-1:0]           in_wp_r, in_rp_r, out_wp_r, out_rp_r;
  logic [CW-1:0]           in_cnt_r, out_cnt_r;
  logic [9:0]              ctrl_r;
  logic [8:0]              ien_r, pend_r, lvl_prev_r;
  logic [8:0]              lvl;
  ddes_pkg::ddes_keys_type keys_r;
  logic [63:0]             iv_r, inbuf_r, res;
  logic [31:0]             half_r, outbuf_r;
  ddes_pkg::ddes_state_type state_r;
  logic                    acc, wr, rd;
  logic                    in_push, in_pop, out_push, out_pop;
  logic [DW-1:0]           out_word;
  logic                    can_start, inav, oval;
  logic [CW-1:0]           thr;
  logic                    core_done;
  logic [63:0]             core_blk;

  // Merge a write under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  // ----------------------------------------------------------------
  // Bus access decode
  // ----------------------------------------------------------------
  // Access completes at the edge where ack is high
  assign acc = wb_cyc_in & wb_stb_in & wb_ack_out;
  assign wr  = acc & wb_we_in;
  assign rd  = acc & ~wb_we_in;

  // Queue ports: writes to a full queue and reads of an empty one are dropped
  assign in_push  = wr & (wb_adr_in == ddes_pkg::REG_QIN) & (in_cnt_r != CW'(DEPTH));
  assign out_pop  = rd & (wb_adr_in == ddes_pkg::REG_QOUT) & (out_cnt_r != '0);
  assign in_pop   = (state_r == ddes_pkg::S_POP1) | (state_r == ddes_pkg::S_POP2);
  assign out_push = core_done | (state_r == ddes_pkg::S_PUSH2);

  // ----------------------------------------------------------------
  // Status levels and thresholds
  // ----------------------------------------------------------------
  always_comb
  begin
    thr  = ctrl_r[ddes_pkg::CTRL_THR] ? CW'(ddes_pkg::THR_NARROW) : CW'(ddes_pkg::THR_WIDE);
    inav = (CW'(DEPTH) - in_cnt_r) >= thr;
    oval = out_cnt_r >= thr;
    lvl  = '0;
    lvl[ddes_pkg::STA_IDLE] = (state_r == ddes_pkg::S_IDLE);
    lvl[ddes_pkg::STA_INAV] = inav;
    lvl[ddes_pkg::STA_OVAL] = oval;
  end

  // Request lines, each routed to DMA when its control bit selects it
  assign in_dma_req_out  = inav & ctrl_r[ddes_pkg::CTRL_IDMA];
  assign out_dma_req_out = oval & ctrl_r[ddes_pkg::CTRL_ODMA];
  assign irq_out         = |(pend_r & ien_r);

  // Engine may start only when a whole block can go in and come out
  assign can_start = ctrl_r[ddes_pkg::CTRL_RUN] & (in_cnt_r >= CW'(2)) &
                     ((CW'(DEPTH) - out_cnt_r) >= CW'(2));

  // ----------------------------------------------------------------
  // Wishbone answer: one wait state, ack drops after one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      wb_ack_out <= 1'b0;
    else
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
  end

  // Read data latched with ack; unmapped offsets read zero
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      wb_dat_out <= '0;
    else if (wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_we_in)
    begin
      unique case (wb_adr_in)
        ddes_pkg::REG_CTRL:      wb_dat_out <= DW'(ctrl_r);
        ddes_pkg::REG_STAT:      wb_dat_out <= DW'({out_cnt_r, in_cnt_r, 3'h0, lvl});
        ddes_pkg::REG_IEN:       wb_dat_out <= DW'(ien_r);
        ddes_pkg::REG_IPEND:     wb_dat_out <= DW'(pend_r);
        ddes_pkg::REG_RUN:       wb_dat_out <= DW'(ctrl_r[ddes_pkg::CTRL_RUN]);
        ddes_pkg::REG_KEY:       wb_dat_out <= keys_r.k1[63:32];
        ddes_pkg::REG_KEY + 8'h04: wb_dat_out <= keys_r.k1[31:0];
        ddes_pkg::REG_KEY + 8'h08: wb_dat_out <= keys_r.k2[63:32];
        ddes_pkg::REG_KEY + 8'h0c: wb_dat_out <= keys_r.k2[31:0];
        ddes_pkg::REG_KEY + 8'h10: wb_dat_out <= keys_r.k3[63:32];
        ddes_pkg::REG_KEY + 8'h14: wb_dat_out <= keys_r.k3[31:0];
        ddes_pkg::REG_IVL:       wb_dat_out <= iv_r[63:32];
        ddes_pkg::REG_IVR:       wb_dat_out <= iv_r[31:0];
        ddes_pkg::REG_QOUT:      wb_dat_out <= (out_cnt_r != '0) ? out_mem[out_rp_r] : '0;
        default:                 wb_dat_out <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control, key and interrupt enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ctrl_r <= ddes_pkg::CTRL_RST;
      ien_r  <= ddes_pkg::IEN_RST;
      keys_r <= '{default: ddes_pkg::KEY_RST};
    end
    else if (wr)
    begin
      unique case (wb_adr_in)
        ddes_pkg::REG_CTRL: ctrl_r <= 10'(merge(32'(ctrl_r), wb_dat_in, wb_sel_in));
        ddes_pkg::REG_IEN:  ien_r  <= 9'(merge(32'(ien_r), wb_dat_in, wb_sel_in));
        // Same bit as the control run enable
        ddes_pkg::REG_RUN:
          if (wb_sel_in[0])
            ctrl_r[ddes_pkg::CTRL_RUN] <= wb_dat_in[0];
        ddes_pkg::REG_KEY:         keys_r.k1[63:32] <= merge(keys_r.k1[63:32], wb_dat_in, wb_sel_in);
        ddes_pkg::REG_KEY + 8'h04: keys_r.k1[31:0]  <= merge(keys_r.k1[31:0], wb_dat_in, wb_sel_in);
        ddes_pkg::REG_KEY + 8'h08: keys_r.k2[63:32] <= merge(keys_r.k2[63:32], wb_dat_in, wb_sel_in);
        ddes_pkg::REG_KEY + 8'h0c: keys_r.k2[31:0]  <= merge(keys_r.k2[31:0], wb_dat_in, wb_sel_in);
        ddes_pkg::REG_KEY + 8'h10: keys_r.k3[63:32] <= merge(keys_r.k3[63:32], wb_dat_in, wb_sel_in);
        ddes_pkg::REG_KEY + 8'h14: keys_r.k3[31:0]  <= merge(keys_r.k3[31:0], wb_dat_in, wb_sel_in);
        default: ;
      endcase
    end
  end

  // Sticky pending on rising status; hardware set beats software clear
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pend_r     <= '0;
      lvl_prev_r <= '0;
    end
    else
    begin
      lvl_prev_r <= lvl;
      if (wr & (wb_adr_in == ddes_pkg::REG_IPEND))
        pend_r <= (pend_r & ~9'(wb_dat_in & {{24{1'b0}}, {8{wb_sel_in[0]}}} |
                                 wb_dat_in & {{23{1'b0}}, wb_sel_in[1], 8'h00}))
                  | (lvl & ~lvl_prev_r);
      else
        pend_r <= pend_r | (lvl & ~lvl_prev_r);
    end
  end

  // ----------------------------------------------------------------
  // Input queue
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (in_push)
      in_mem[in_wp_r] <= wb_dat_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      in_wp_r  <= '0;
      in_rp_r  <= '0;
      in_cnt_r <= '0;
    end
    else
    begin
      if (in_push)
        in_wp_r <= in_wp_r + PW'(1);
      if (in_pop)
        in_rp_r <= in_rp_r + PW'(1);
      in_cnt_r <= in_cnt_r + CW'(in_push) - CW'(in_pop);
    end
  end

  // ----------------------------------------------------------------
  // Output queue
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (out_push)
      out_mem[out_wp_r] <= out_word;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      out_wp_r  <= '0;
      out_rp_r  <= '0;
      out_cnt_r <= '0;
    end
    else
    begin
      if (out_push)
        out_wp_r <= out_wp_r + PW'(1);
      if (out_pop)
        out_rp_r <= out_rp_r + PW'(1);
      out_cnt_r <= out_cnt_r + CW'(out_push) - CW'(out_pop);
    end
  end

  // ----------------------------------------------------------------
  // Result path
  // ----------------------------------------------------------------
  // Chaining decrypt folds the previous IV into the core output
  always_comb
  begin
    if (ctrl_r[ddes_pkg::CTRL_CBC] & ctrl_r[ddes_pkg::CTRL_DEC])
      res = core_blk ^ iv_r;
    else
      res = core_blk;
    // First word out is left half unless swapped
    if (core_done)
      out_word = ctrl_r[ddes_pkg::CTRL_SWAP] ? res[31:0] : res[63:32];
    else
      out_word = outbuf_r;
  end

  // ----------------------------------------------------------------
  // Block sequencer: 2 pop, 1 feed, core, 2 push = 25 or 65 cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state_r <= ddes_pkg::S_IDLE;
    else
    begin
      unique case (state_r)
        ddes_pkg::S_IDLE:  if (can_start) state_r <= ddes_pkg::S_POP1;
        ddes_pkg::S_POP1:  state_r <= ddes_pkg::S_POP2;
        ddes_pkg::S_POP2:  state_r <= ddes_pkg::S_FEED;
        ddes_pkg::S_FEED:  state_r <= ddes_pkg::S_CORE;
        ddes_pkg::S_CORE:  if (core_done) state_r <= ddes_pkg::S_PUSH2;
        ddes_pkg::S_PUSH2: state_r <= ddes_pkg::S_IDLE;
      endcase
    end
  end

  // Assemble the block from two queue words, first written word left unless swapped
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      half_r  <= '0;
      inbuf_r <= '0;
    end
    else if (state_r == ddes_pkg::S_POP1)
      half_r <= in_mem[in_rp_r];
    else if (state_r == ddes_pkg::S_POP2)
    begin
      if (ctrl_r[ddes_pkg::CTRL_SWAP])
        inbuf_r <= {in_mem[in_rp_r], half_r};
      else
        inbuf_r <= {half_r, in_mem[in_rp_r]};
    end
  end

  // Second result word parked in the output buffer
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      outbuf_r <= '0;
    else if (core_done)
      outbuf_r <= ctrl_r[ddes_pkg::CTRL_SWAP] ? res[63:32] : res[31:0];
  end

  // IV follows the last ciphertext block in chaining mode
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      iv_r <= '0;
    else if (wr & (wb_adr_in == ddes_pkg::REG_IVL))
      iv_r[63:32] <= merge(iv_r[63:32], wb_dat_in, wb_sel_in);
    else if (wr & (wb_adr_in == ddes_pkg::REG_IVR))
      iv_r[31:0] <= merge(iv_r[31:0], wb_dat_in, wb_sel_in);
    else if (core_done & ctrl_r[ddes_pkg::CTRL_CBC])
      iv_r <= ctrl_r[ddes_pkg::CTRL_DEC] ? inbuf_r : core_blk;
  end

  // ----------------------------------------------------------------
  // Cipher core
  // ----------------------------------------------------------------
  ddes_core #(
    .PASS_CYC (ddes_pkg::DES_PASS_CYC)
  ) u_core (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (state_r == ddes_pkg::S_FEED),
    .tdes_in  (ctrl_r[ddes_pkg::CTRL_TDES]),
    .dec_in   (ctrl_r[ddes_pkg::CTRL_DEC]),
    .keys_in  (keys_r),
    // Chaining encrypt mixes the IV in before the core
    .blk_in   ((ctrl_r[ddes_pkg::CTRL_CBC] & ~ctrl_r[ddes_pkg::CTRL_DEC]) ? inbuf_r ^ iv_r : inbuf_r),
    .done_out (core_done),
    .blk_out  (core_blk)
  );

endmodule : ddes_top

// [rtl/ddes_pkg.sv]
// Package: register map, field positions, timing and shared types of the cipher data path
package ddes_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_IEN   = 8'h08;
  localparam logic [7:0] REG_IPEND = 8'h0c;
  localparam logic [7:0] REG_RUN   = 8'h10;
  localparam logic [7:0] REG_KEY   = 8'h14;  // Six words: k1 left/right, k2, k3
  localparam logic [7:0] REG_IVL   = 8'h2c;
  localparam logic [7:0] REG_IVR   = 8'h30;
  localparam logic [7:0] REG_QIN   = 8'h34;
  localparam logic [7:0] REG_QOUT  = 8'h38;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_DEC  = 1;
  localparam int CTRL_CBC  = 2;
  localparam int CTRL_SWAP = 3;
  localparam int CTRL_TDES = 5;
  localparam int CTRL_THR  = 7;
  localparam int CTRL_IDMA = 8;
  localparam int CTRL_ODMA = 9;
  localparam int STA_IDLE  = 0;
  localparam int STA_INAV  = 4;
  localparam int STA_OVAL  = 8;

  // ----------------------------------------------------------------
  // Reset values, thresholds and timing
  // ----------------------------------------------------------------
  localparam logic [9:0]  CTRL_RST     = 10'h000;
  localparam logic [8:0]  IEN_RST      = 9'h000;
  localparam logic [63:0] KEY_RST      = 64'h0;
  localparam int          THR_WIDE     = 4;
  localparam int          THR_NARROW   = 2;
  localparam int          DES_PASS_CYC = 20;
  localparam int          TDES_PASSES  = 3;
  localparam int          QUEUE_DEPTH  = 8;

  // Key set handed to the core
  typedef struct packed {
    logic [63:0] k1;
    logic [63:0] k2;
    logic [63:0] k3;
  } ddes_keys_type;

  // Block sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_POP1, S_POP2, S_FEED, S_CORE, S_PUSH2
  } ddes_state_type;

endpackage : ddes_pkg

// [rtl/ddes_core.sv]
// Fixed-latency block cipher core: one or three Feistel passes
`timescale 1ns/100ps
module ddes_core #(
  parameter int PASS_CYC = ddes_pkg::DES_PASS_CYC
) (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // Control
  input  wire logic                   start_in,
  input  wire logic                   tdes_in,
  input  wire logic                   dec_in,
  input  wire ddes_pkg::ddes_keys_type keys_in,
  input  wire logic [63:0]            blk_in,
  // Result
  output logic                        done_out,
  output logic [63:0]                 blk_out
);

  logic       busy_r;
  logic [6:0] cnt_r;
  logic [6:0] last;
  logic [6:0] rnd;
  logic [1:0] pass;
  logic       pdec;
  logic [63:0] pkey;
  logic [31:0] sk;
  logic [31:0] fval;

  // Drop the parity bit of every key byte, 56 bits remain
  function automatic logic [55:0] key56(input logic [63:0] k);
    logic [55:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      r[i*7 +: 7] = k[i*8+1 +: 7];
    return r;
  endfunction : key56

  // Round subkey: effective key rotated by the round index
  function automatic logic [31:0] subkey(input logic [55:0] k, input logic [6:0] idx);
    logic [111:0] d;
    d = {k, k} >> idx;
    return d[31:0];
  endfunction : subkey

  // ----------------------------------------------------------------
  // Round schedule
  // ----------------------------------------------------------------
  always_comb
  begin
    last = tdes_in ? 7'(PASS_CYC * ddes_pkg::TDES_PASSES - 1) : 7'(PASS_CYC - 1);
    pass = 2'(cnt_r / 7'(PASS_CYC));
    rnd  = 7'(cnt_r % 7'(PASS_CYC));
    pdec = dec_in ^ (pass == 2'd1);  // Middle pass runs the other way
    // Only key1 in single mode; keys reversed when decrypting
    if (!tdes_in)
      pkey = keys_in.k1;
    else if (pass == 2'd1)
      pkey = keys_in.k2;
    else if ((pass == 2'd0) ^ dec_in)
      pkey = keys_in.k1;
    else
      pkey = keys_in.k3;
    sk   = subkey(key56(pkey), pdec ? 7'(PASS_CYC - 1) - rnd : rnd);
    fval = ({blk_out[4:0], blk_out[31:5]} & blk_out[31:0]) ^ {blk_out[23:0], blk_out[31:24]} ^ sk;
  end

  // ----------------------------------------------------------------
  // Feistel rounds, last round of each pass keeps halves in place
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      busy_r   <= 1'b0;
      cnt_r    <= '0;
      done_out <= 1'b0;
      blk_out  <= '0;
    end
    else
    begin
      done_out <= 1'b0;
      if (start_in)
      begin
        busy_r  <= 1'b1;
        cnt_r   <= '0;
        blk_out <= blk_in;
      end
      else if (busy_r)
      begin
        if (rnd == 7'(PASS_CYC - 1))
          blk_out <= {blk_out[63:32] ^ fval, blk_out[31:0]};
        else
          blk_out <= {blk_out[31:0], blk_out[63:32] ^ fval};
        if (cnt_r == last)
        begin
          busy_r   <= 1'b0;
          done_out <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 7'd1;
      end
    end
  end

endmodule : ddes_core

// [bench/ddes_top_chk.sv]
// Checker: bus handshake, request and interrupt relations at the ports
`timescale 1ns/100ps
module ddes_top_chk #(
  parameter int DEPTH = 8,
  parameter int DW    = 32
) (
  // Watched ports
  input wire logic          clk_in,
  input wire logic          rst_in,
  input wire logic          wb_cyc_in,
  input wire logic          wb_stb_in,
  input wire logic          wb_we_in,
  input wire logic [7:0]    wb_adr_in,
  input wire logic [3:0]    wb_sel_in,
  input wire logic [DW-1:0] wb_dat_in,
  input wire logic [DW-1:0] wb_dat_out,
  input wire logic          wb_ack_out,
  input wire logic          irq_out,
  input wire logic          in_dma_req_out,
  input wire logic          out_dma_req_out
);
  // ----------------------------------------
  // Assertions, one clock domain
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  ack_one_wait_a: assert property ($rose(wb_stb_in) && wb_cyc_in |=> wb_ack_out)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held two cycles");
  ack_cause_a: assert property (wb_ack_out |-> $past(wb_stb_in) && $past(wb_cyc_in) && wb_cyc_in)
    else $error("ack without request");
  read_zero_a: assert property (wb_ack_out && !wb_we_in && (wb_adr_in == ddes_pkg::REG_QIN ||
    wb_adr_in > ddes_pkg::REG_QOUT) |-> wb_dat_out == '0) else $error("write-only or unmapped read not zero");
  irq_mask_a: assert property (wb_ack_out && wb_we_in && wb_adr_in == ddes_pkg::REG_IEN &&
    wb_dat_in == '0 |=> !irq_out [*2]) else $error("irq while all enables clear");
  in_req_off_a: assert property (wb_ack_out && wb_we_in && wb_adr_in == ddes_pkg::REG_CTRL &&
    !wb_dat_in[ddes_pkg::CTRL_IDMA] |=> !in_dma_req_out) else $error("input request while disabled");
  out_req_off_a: assert property (wb_ack_out && wb_we_in && wb_adr_in == ddes_pkg::REG_CTRL &&
    !wb_dat_in[ddes_pkg::CTRL_ODMA] |=> !out_dma_req_out) else $error("output request while disabled");
  reset_quiet_a: assert property ($fell(rst_in) |-> !wb_ack_out && !irq_out &&
    !in_dma_req_out && !out_dma_req_out) else $error("outputs active after reset");
endmodule : ddes_top_chk

bind ddes_top ddes_top_chk #(.DEPTH(DEPTH), .DW(DW)) chk (.clk_in(clk_in), .rst_in(rst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .irq_out(irq_out), .in_dma_req_out(in_dma_req_out), .out_dma_req_out(out_dma_req_out));

// [bench/ddes_master.sv]
// Partner model: processor-side classic bus master
`timescale 1ns/100ps
module ddes_master (
  // Clock and answer
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] dat_in,
  // Request
  output logic             cyc_out,
  output logic             stb_out,
  output logic             we_out,
  output logic [7:0]       adr_out,
  output logic [3:0]       sel_out,
  output logic [31:0]      dat_out,
  // Stuck bus flag
  output logic             hang_out
);
  // Bus idle from time zero
  initial
  begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out = 1'b0;
    adr_out = 8'h00;
    sel_out = 4'hf;
    dat_out = 32'h0;
    hang_out = 1'b0;
  end

  // One cycle; held until ack is sampled, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= w;
    adr_out <= a;
    dat_out <= d;
    n = 0;
    @(posedge clk_in);
    while (ack_in !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_in);
    end
    q = dat_in;
    hang_out <= hang_out | (n >= 20);
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    @(posedge clk_in);
  endtask : xfer
endmodule : ddes_master

// [bench/tb.sv]
// Testbench: block order, thresholds, timing, chaining and interrupts
`timescale 1ns/100ps
module tb;
  logic        clk_in, rst_in, cyc, stb, we, ack, irq, ireq, oreq, hang;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [63:0] p, r0, r1, k;
  integer      seed, miscompares, tests_run, cs, ct, i, n;
  logic [31:0] mq[$];  // Model of the words the input queue accepted

  ddes_top uut (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .irq_out(irq), .in_dma_req_out(ireq), .out_dma_req_out(oreq));
  ddes_master m (.clk_in(clk_in), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc), .stb_out(stb),
    .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat), .hang_out(hang));

  // 100 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic stop_test();
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // A stuck bus ends the run
  always @(posedge clk_in)
  begin
    if (hang === 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    m.xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    m.xfer(1'b0, a, 32'h0, d);
  endtask : rd

  // Key words go left half first
  task automatic keys(input logic [63:0] a, input logic [63:0] b, input logic [63:0] c);
    logic [191:0] v;
    v = {a, b, c};
    for (int j = 0; j < 6; j++)
      wr(ddes_pkg::REG_KEY + 8'(4 * j), v[191 - 32 * j -: 32]);
  endtask : keys

  // Bounded wait for two result words; cycles counted from start
  task automatic wait_oreq(output integer c);
    c = 0;
    while (oreq !== 1'b1 && c < 200)
    begin
      @(posedge clk_in);
      c++;
    end
    if (c >= 200)
    begin
      miscompares++;
      stop_test();
    end
  endtask : wait_oreq

  // One block: load halted, start by run bit, read back in swap order
  task automatic blk(input logic [63:0] d, input logic [9:0] cfg, output logic [63:0] r, output integer c);
    logic [31:0] a, b;
    wr(ddes_pkg::REG_CTRL, {22'h0, cfg} | 32'h280);
    a = cfg[3] ? d[31:0] : d[63:32];
    b = cfg[3] ? d[63:32] : d[31:0];
    wr(ddes_pkg::REG_QIN, a);
    wr(ddes_pkg::REG_QIN, b);
    repeat (30) @(posedge clk_in);
    chk(64'(oreq), 64'h0);
    wr(ddes_pkg::REG_RUN, 32'h1);
    wait_oreq(c);
    rd(ddes_pkg::REG_QOUT, a);
    rd(ddes_pkg::REG_QOUT, b);
    r = cfg[3] ? {b, a} : {a, b};
  endtask : blk

  // Main sequence
  initial
  begin
    seed = 25;
    miscompares = 0;
    tests_run = 0;
    rst_in = 1'b1;
    do_reset();
    rd(ddes_pkg::REG_CTRL, q);
    chk(64'(q), 64'h0);
    rd(ddes_pkg::REG_STAT, q);
    chk(64'(q), 64'h11);
    wr(ddes_pkg::REG_IEN, 32'h10);
    chk(64'(irq), 64'h1);
    wr(ddes_pkg::REG_IPEND, 32'h10);
    chk(64'(irq), 64'h0);
    rd(8'h3c, q);
    chk(64'(q), 64'h0);
    // Both thresholds: fill past full, run, drain past empty
    for (i = 0; i < 2; i++)
    begin
      do_reset();
      wr(ddes_pkg::REG_IEN, 32'h100);
      wr(ddes_pkg::REG_CTRL, i ? 32'h180 : 32'h100);
      mq.delete();
      for (n = 0; n < 9; n++)
      begin
        chk(64'(ireq), 64'((8 - n) >= (i ? 2 : 4)));
        q = $random(seed);
        wr(ddes_pkg::REG_QIN, q);
        // A full queue drops the ninth word
        if (mq.size() < ddes_pkg::QUEUE_DEPTH)
          mq.push_back(q);
      end
      // Input count sits above the status levels and three spare bits
      rd(ddes_pkg::REG_STAT, q);
      chk(64'(q[15:12]), 64'(mq.size()));
      wr(ddes_pkg::REG_CTRL, i ? 32'h381 : 32'h301);
      repeat (120) @(posedge clk_in);
      chk(64'(irq), 64'h1);
      // Every accepted word comes back as a result word
      rd(ddes_pkg::REG_STAT, q);
      chk(64'(q[19:16]), 64'(mq.size()));
      for (n = 8; n >= 0; n--)
      begin
        chk(64'(oreq), 64'(n >= (i ? 2 : 4)));
        rd(ddes_pkg::REG_QOUT, q);
      end
      chk(64'(q), 64'h0);
    end
    // Cipher relations with random key and data
    do_reset();
    k = {$random(seed), $random(seed)};
    p = {$random(seed), $random(seed)};
    keys(k, ~k, k ^ 64'h5a);
    blk(p, 10'h000, r0, cs);
    // 25-cycle block plus the edge that samples the raised request
    chk(64'(cs), 64'd26);
    rd(ddes_pkg::REG_CTRL, q);
    chk(64'(q[0]), 64'h1);
    blk(p, 10'h008, r1, n);
    chk(r1, r0);
    keys(k ^ 64'h0101010101010101, k, ~k);
    blk(p, 10'h000, r1, n);
    chk(r1, r0);
    blk(r0, 10'h002, r1, n);
    chk(r1, p);
    keys(k, k, k);
    blk(p, 10'h020, r1, ct);
    chk(r1, r0);
    chk(64'(ct - cs), 64'd40);
    wr(ddes_pkg::REG_IVL, 32'h0);
    wr(ddes_pkg::REG_IVR, 32'h0);
    blk(p, 10'h004, r1, n);
    chk(r1, r0);
    rd(ddes_pkg::REG_IVL, q);
    chk(64'(q), 64'(r0[63:32]));
    blk(p, 10'h004, r1, n);
    blk(p ^ r0, 10'h000, r0, n);
    chk(r1, r0);
    wr(ddes_pkg::REG_IEN, 32'h0);
    wr(ddes_pkg::REG_CTRL, 32'h0);
    chk(64'(irq), 64'h0);
    stop_test();
  end
endmodule : tb
